// >>> rcs_asserts.sv
// Checker on the reset sequencer ports.
// Assumes one clock domain; attached by the bind below.
`timescale 1ns/100ps
`default_nettype none
module rcs_asserts
	import rcs_pkg::*;
#(
	parameter int DRIVE_CYCLES = 512,
	parameter int RELEASE_CYCLES = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rstPinOut,
	input wire logic rstPinOe,
	input wire logic floatAllOutputs,
	input wire logic sysReset,
	input wire logic modReset,
	input wire logic portReset,
	input wire logic outputsFloat,
	input wire logic [1:0] modeCfg,
	input wire logic modeSelExt,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic [31:0] prdata
);
	// ****************
	// Properties
	// ****************
	logic [15:0] hiRun, loRun, fltRun;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Run lengths saturate so long idle spells never wrap
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hiRun <= 16'h0;
			loRun <= 16'h0;
			fltRun <= 16'h0;
		end else begin
			hiRun <= rstPinOe ? hiRun + {15'h0, ~&hiRun} : 16'h0;
			loRun <= rstPinOe ? 16'h0 : loRun + {15'h0, ~&loRun};
			fltRun <= floatAllOutputs ? fltRun + {15'h0, ~&fltRun} : 16'h0;
		end
	end
	// A float drops the pin enable at any time, so that fall is not a drive end
	property p_drive; $fell(rstPinOe) && !outputsFloat |-> hiRun >= DRIVE_CYCLES; endproperty
	a_drive: assert property (p_drive) else $error("drive too short");
	property p_redrive; $rose(rstPinOe) && $past(sysReset) |-> loRun >= RELEASE_CYCLES; endproperty
	a_redrive: assert property (p_redrive) else $error("release too short");
	property p_exit; $fell(sysReset) |-> loRun >= RELEASE_CYCLES && !rstPinOe; endproperty
	a_exit: assert property (p_exit) else $error("exit without release");
	property p_mod4; $rose(modReset) |-> $past(sysReset) && $past(sysReset, 4); endproperty
	a_mod4: assert property (p_mod4) else $error("modules reset early");
	property p_sticky; outputsFloat |=> outputsFloat && sysReset; endproperty
	a_sticky: assert property (p_sticky) else $error("float left");
	property p_float; $rose(outputsFloat) && !modeSelExt |-> fltRun >= RCS_FLOAT_CYCLES; endproperty
	a_float: assert property (p_float) else $error("float too early");
	property p_apb; psel && penable && !pready |=> pready; endproperty
	a_apb: assert property (p_apb) else $error("read not answered");
	property p_instr;
		pready && !pwrite && paddr == RCS_ADDR_CAUSE |-> prdata[31:8] == 24'h0 && !prdata[1] && !prdata[3];
	endproperty
	a_instr: assert property (p_instr) else $error("cause fixed bits set");
	property p_drain; rstPinOut == 1'b0 && (portReset || !sysReset); endproperty
	a_drain: assert property (p_drain) else $error("pins not held in reset");
	property p_mode; !sysReset && !$past(sysReset) |-> $stable(modeCfg); endproperty
	a_mode: assert property (p_mode) else $error("mode changed in run");
	c_redrive: cover property ($rose(rstPinOe) && $past(sysReset));
	c_float: cover property ($rose(outputsFloat));
	c_exit: cover property ($fell(sysReset));
endmodule : rcs_asserts
bind rcs_reset_sequencer rcs_asserts #(
	.DRIVE_CYCLES(DRIVE_CYCLES),
	.RELEASE_CYCLES(RELEASE_CYCLES)
) u_rcs_asserts (
	.clk(clk), .rst_n(rst_n), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
	.floatAllOutputs(floatAllOutputs), .sysReset(sysReset), .modReset(modReset), .portReset(portReset),
	.outputsFloat(outputsFloat), .modeCfg(modeCfg), .modeSelExt(modeSelExt),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pready(pready), .prdata(prdata)
);
`default_nettype wire

// >>> rcs_pin_model.sv
// Partner model: system logic sharing the open-drain reset line.
// Assumes the bench commands the external hold on the system clock.
`timescale 1ns/100ps
`default_nettype none
module rcs_pin_model
	import rcs_pkg::*;
#(
	parameter int MIN_HOLD = 4
) (
	input wire logic clk,
	input wire logic holdReq,
	input wire logic devOe,
	output logic pinLevel
);
	// ****************
	// Line drive
	// ****************
	logic [7:0] held = 8'h00;
	logic extLow = 1'b0;
	always_ff @(posedge clk) begin
		if (holdReq || (extLow && held < MIN_HOLD)) begin
			extLow <= 1'b1;
			held <= extLow ? held + 8'h01 : 8'h01;
		end else begin
			extLow <= 1'b0;
		end
	end
	// Pull-up wins only when nobody pulls low
	assign pinLevel = !(extLow || devOe);
endmodule : rcs_pin_model
`default_nettype wire

// >>> rcs_pkg.sv
// Package for the reset control sequencer: register map, cause bit layout,
// timing counts and the state carriers shared by the design.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
package rcs_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] RCS_ADDR_CAUSE = 8'h00;
	localparam logic [7:0] RCS_ADDR_CTRL = 8'h04;
	localparam logic [7:0] RCS_ADDR_STATE = 8'h08;
	localparam int RCS_CAUSE_W = 16;

	// Cause flag positions
	localparam int RCS_BIT_PIN = 7;
	localparam int RCS_BIT_SUPPLY = 6;
	localparam int RCS_BIT_WDOG = 5;
	localparam int RCS_BIT_HALT = 4;
	localparam int RCS_BIT_ZERO = 3;
	localparam int RCS_BIT_REF = 2;
	localparam int RCS_BIT_INSTR = 1;
	localparam int RCS_BIT_TEST = 0;

	// Control register fields
	localparam int RCS_CTRL_REFEN = 0;
	localparam int RCS_CTRL_OSCEN = 1;
	localparam logic [1:0] RCS_CTRL_RESET = 2'h0;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int RCS_CLK_HZ = 40000000;
	localparam int RCS_DRIVE_CYCLES = 512;
	localparam int RCS_RELEASE_CYCLES = 10;
	localparam int RCS_INT_ASSERT_CYCLES = 4;
	localparam int RCS_FLOAT_CYCLES = 10;
	localparam int RCS_XTAL_PULSES = 10;
	localparam int RCS_CNT_W = 10;

	typedef enum {
		RCS_ST_POWER,
		RCS_ST_INTRST,
		RCS_ST_LOCKWAIT,
		RCS_ST_RUN,
		RCS_ST_WAITBUS,
		RCS_ST_EXTHOLD,
		RCS_ST_DRIVE,
		RCS_ST_RELEASE
	} rcs_state_t;

	// Internal reset requests travel together
	typedef struct packed {
		logic watchdog;
		logic haltMon;
		logic refLoss;
		logic test;
	} rcs_req_t;

	typedef struct packed {
		rcs_state_t state;
		logic [RCS_CNT_W-1:0] count;
		logic [7:0] pending;
		logic [7:0] cause;
		logic [1:0] ctrl;
		logic [3:0] floatCnt;
		logic [3:0] xtalCnt;
		logic floated;
		logic rstPinOe;
		logic sysReset;
		logic modReset;
		logic portReset;
		logic [1:0] modeCfg;
		logic modeSelExt;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} rcs_regs_t;
endpackage : rcs_pkg

// >>> rcs_reset_sequencer.sv
// Reset control sequencer: qualifies reset sources, stretches reset on the
// open-drain pin, records the cause, and handles the float-all-outputs input.
// Assumes an APB master on clk and pin inputs that are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module rcs_reset_sequencer
	import rcs_pkg::*;
#(
	parameter int DRIVE_CYCLES = RCS_DRIVE_CYCLES,
	parameter int RELEASE_CYCLES = RCS_RELEASE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic supplyGood,
	input wire logic pllLocked,
	input wire logic rstPinIn,
	output logic rstPinOut,
	output logic rstPinOe,
	input wire rcs_req_t intReq,
	input wire logic busCycleEnd,
	input wire logic floatAllOutputs,
	input wire logic clockSourceSelect,
	input wire logic crystalInput,
	input wire logic [1:0] modePins,
	output logic sysReset,
	output logic modReset,
	output logic portReset,
	output logic outputsFloat,
	output logic [1:0] modeCfg,
	output logic modeSelExt,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr
);
	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	localparam int SYNC_N = 8;
	logic [SYNC_N-1:0] syncIn;
	logic [SYNC_N-1:0] syncA;
	logic [SYNC_N-1:0] syncB;
	logic xtalPrev;
	rcs_regs_t r;
	rcs_regs_t next_r;

	assign syncIn = {supplyGood, pllLocked, rstPinIn, floatAllOutputs,
		clockSourceSelect, crystalInput, modePins};

	// pin sampled on clock; two flops before any logic
	// The crystal edge detector resets low, the idle level of that input,
	// so leaving reset never shows a false crystal pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= '0;
			syncB <= '0;
			xtalPrev <= 1'b0;
		end else begin
			syncA <= syncIn;
			syncB <= syncA;
			xtalPrev <= syncB[2];
		end
	end

	logic sSupply;
	logic sLock;
	logic sPin;
	logic sFloat;
	logic sClkSel;
	logic sXtal;
	logic [1:0] sMode;
	assign sSupply = syncB[7];
	assign sLock = syncB[6];
	assign sPin = syncB[5];
	assign sFloat = syncB[4];
	assign sClkSel = syncB[3];
	assign sXtal = syncB[2];
	assign sMode = syncB[1:0];

	// Decode of one APB register address
	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction : hit

	// ****************************************************************
	// Sequencer and register file
	// ****************************************************************
	logic [7:0] srcNow;
	logic intActive;
	logic refLossOk;
	logic apbAccess;

	// reference loss counts only when enabled twice over
	// Control powers up clear, so a reference loss is ignored until software arms it
	assign refLossOk = intReq.refLoss & r.ctrl[RCS_CTRL_REFEN] & r.ctrl[RCS_CTRL_OSCEN];
	assign intActive = intReq.watchdog | intReq.haltMon | refLossOk | intReq.test;
	// The registered pready keeps one access from being taken twice
	assign apbAccess = psel & penable & ~r.pready;

	// each source lands on its fixed cause bit
	// every active source but supply gathered into one vector
	always_comb begin
		srcNow = '0;
		srcNow[RCS_BIT_WDOG] = intReq.watchdog;
		srcNow[RCS_BIT_HALT] = intReq.haltMon;
		srcNow[RCS_BIT_REF] = refLossOk;
		srcNow[RCS_BIT_TEST] = intReq.test;
		srcNow[RCS_BIT_PIN] = ~sPin;
	end

	// Next-state logic for the whole block
	always_comb begin
		next_r = r;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;

		// float request must stand ten cycles
		// Limitation: a crystal pulse shorter than one clock can be lost in the synchroniser
		if (sFloat && !r.floated) begin
			if (r.floatCnt != 4'(RCS_FLOAT_CYCLES - 1)) begin
				next_r.floatCnt = r.floatCnt + 4'h1;
			end else if (sClkSel) begin
				next_r.floated = 1'b1;
			end
			// external clock counts crystal rising edges instead
			if (!sClkSel && sXtal && !xtalPrev) begin
				if (r.xtalCnt == 4'(RCS_XTAL_PULSES - 1)) begin
					next_r.floated = 1'b1;
				end else begin
					next_r.xtalCnt = r.xtalCnt + 4'h1;
				end
			end
		end else if (!r.floated) begin
			next_r.floatCnt = '0;
			next_r.xtalCnt = '0;
		end

		// internal reset overrides normal run regardless of activity; pin reset waits for the bus cycle
		case (r.state)
			// power-on holds both lines until supply good
			// Supply flag marked here so it survives to the reset exit
			RCS_ST_POWER: begin
				next_r.pending[RCS_BIT_SUPPLY] = 1'b1;
				next_r.rstPinOe = 1'b1;
				next_r.sysReset = 1'b1;
				if (sSupply) begin
					next_r.count = '0;
					next_r.state = RCS_ST_INTRST;
				end
			end
			// modules reset after four cycles of internal reset
			RCS_ST_INTRST: begin
				next_r.count = r.count + 1'b1;
				if (r.count == RCS_CNT_W'(RCS_INT_ASSERT_CYCLES - 1)) begin
					next_r.modReset = 1'b1;
					next_r.count = '0;
					next_r.state = RCS_ST_LOCKWAIT;
				end
			end
			// lock then 512 cycles before pin release
			// A lost lock restarts the count rather than shortening the hold
			RCS_ST_LOCKWAIT: begin
				if (!sLock) begin
					next_r.count = '0;
				end else if (r.count == RCS_CNT_W'(DRIVE_CYCLES - 1)) begin
					next_r.count = '0;
					next_r.rstPinOe = 1'b0;
					next_r.state = RCS_ST_RELEASE;
				end else begin
					next_r.count = r.count + 1'b1;
				end
			end
			RCS_ST_RUN: begin
				if (intActive) begin
					// internal faults are catastrophic, act on this edge
					next_r.pending = srcNow;
					next_r.sysReset = 1'b1;
					next_r.rstPinOe = 1'b1;
					next_r.count = '0;
					next_r.state = RCS_ST_DRIVE;
				end else if (!sPin) begin
					// pin reset waits for the bus cycle to end
					next_r.pending = srcNow;
					next_r.state = RCS_ST_WAITBUS;
				end
			end
			RCS_ST_WAITBUS: begin
				next_r.pending = r.pending | srcNow;
				if (busCycleEnd || intActive) begin
					next_r.sysReset = 1'b1;
					next_r.state = RCS_ST_EXTHOLD;
				end
			end
			// latch external reset until the driver lets go
			RCS_ST_EXTHOLD: begin
				next_r.pending = r.pending | srcNow;
				if (sPin) begin
					next_r.rstPinOe = 1'b1;
					next_r.count = '0;
					next_r.state = RCS_ST_DRIVE;
				end
			end
			// drive at least 512, longer while requested
			// Our own pull-down must not be mistaken for an external pin source
			RCS_ST_DRIVE: begin
				next_r.pending = r.pending | (srcNow & ~(8'h01 << RCS_BIT_PIN));
				if (r.count != RCS_CNT_W'(DRIVE_CYCLES - 1)) begin
					next_r.count = r.count + 1'b1;
				end else if (!intActive) begin
					next_r.count = '0;
					next_r.rstPinOe = 1'b0;
					next_r.state = RCS_ST_RELEASE;
				end
			end
			// release ten cycles, then test the pin
			// Hazard: the pin synchroniser eats two released cycles, so the
			// release count must stay above two or the test sees a stale low
			RCS_ST_RELEASE: begin
				if (r.count != RCS_CNT_W'(RELEASE_CYCLES - 1)) begin
					next_r.count = r.count + 1'b1;
				end else if (!sPin || intActive) begin
					next_r.count = '0;
					next_r.rstPinOe = 1'b1;
					next_r.state = RCS_ST_DRIVE;
				end else begin
					next_r.cause = r.pending;
					// instruction flag and fixed zero never set
					next_r.cause[RCS_BIT_INSTR] = 1'b0;
					next_r.cause[RCS_BIT_ZERO] = 1'b0;
					next_r.pending = '0;
					next_r.sysReset = 1'b0;
					next_r.modReset = 1'b0;
					next_r.count = '0;
					next_r.state = RCS_ST_RUN;
				end
			end
			default: begin
				next_r.state = RCS_ST_POWER;
			end
		endcase

		// mode pins captured while reset is active
		// Captured every reset cycle so the value just before exit is kept
		if (next_r.sysReset) begin
			next_r.modeCfg = sMode;
			next_r.modeSelExt = ~sClkSel;
		end
		// port pins forced to inputs during reset
		next_r.portReset = next_r.sysReset;

		// after floating, hold system and port reset until power cycles
		// The pin enable drops too, so the reset pin floats with the rest
		if (r.floated) begin
			next_r.sysReset = 1'b1;
			next_r.portReset = 1'b1;
			next_r.rstPinOe = 1'b0;
		end

		// APB slave, one wait state; cause is read-only
		// Unmapped offsets answer with an error and change no register
		if (apbAccess) begin
			next_r.pready = 1'b1;
			next_r.prdata = '0;
			if (hit(paddr, RCS_ADDR_CAUSE)) begin
				// flags in the low byte, upper bits unused
				next_r.prdata[7:0] = r.cause;
				next_r.pslverr = 1'b0;
			end else if (hit(paddr, RCS_ADDR_CTRL)) begin
				next_r.prdata[1:0] = r.ctrl;
				if (pwrite) begin
					next_r.ctrl = pwdata[1:0];
				end
			end else if (hit(paddr, RCS_ADDR_STATE)) begin
				next_r.prdata[0] = r.sysReset;
				next_r.prdata[1] = r.floated;
				next_r.prdata[3:2] = r.modeCfg;
				next_r.prdata[4] = r.modeSelExt;
			end else begin
				next_r.pslverr = 1'b1;
			end
		end
	end

	// State register; constants only under reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{state: RCS_ST_POWER, count: '0, pending: '0, cause: '0,
				ctrl: RCS_CTRL_RESET, floatCnt: '0, xtalCnt: '0, floated: 1'b0,
				rstPinOe: 1'b1, sysReset: 1'b1, modReset: 1'b0, portReset: 1'b1,
				modeCfg: '0, modeSelExt: 1'b0, pready: 1'b0, prdata: '0,
				pslverr: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	// ****************************************************************
	// Outputs, all straight from flip-flops but the tied-low rstPinOut
	// ****************************************************************
	assign rstPinOut = 1'b0; // Open drain: only ever pulls low
	assign rstPinOe = r.rstPinOe;
	assign sysReset = r.sysReset;
	assign modReset = r.modReset;
	assign portReset = r.portReset;
	assign outputsFloat = r.floated;
	assign modeCfg = r.modeCfg;
	assign modeSelExt = r.modeSelExt;
	assign pready = r.pready;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr;
endmodule : rcs_reset_sequencer

`default_nettype wire

// >>> rcs_tb.sv
// Directed bench for the reset sequencer over APB.
// Assumes short counts (drive 8, release 3) and the pin partner model.
`timescale 1ns/100ps
`default_nettype none
module tb
	import rcs_pkg::*;
;
	// ****************
	// Harness
	// ****************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic supplyGood = 1'b0;
	logic pllLocked = 1'b0;
	logic hold = 1'b0;
	logic floatReq = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic busEnd = 1'b1;
	logic clkSel = 1'b1;
	logic xtal = 1'b0;
	logic pinData, portReset, modeExt;
	rcs_req_t intReq = 4'h0;
	logic rstPinIn, rstPinOe, sysReset, modReset, outputsFloat, pready, pslverr, e;
	logic [1:0] modeCfg;
	logic [31:0] prdata, r;
	logic [3:0] reqs[4] = '{4'h8, 4'h4, 4'h1, 4'hC};
	logic [31:0] exps[4] = '{32'h20, 32'h10, 32'h01, 32'h30};
	int n_errors = 0;
	int n_compared = 0;
	always #12.5 clk = ~clk;
	rcs_reset_sequencer #(.DRIVE_CYCLES(8), .RELEASE_CYCLES(3)) u_rcs_reset_sequencer (
		.clk(clk), .rst_n(rst_n), .supplyGood(supplyGood), .pllLocked(pllLocked),
		.rstPinIn(rstPinIn), .rstPinOut(pinData), .rstPinOe(rstPinOe), .intReq(intReq),
		.busCycleEnd(busEnd), .floatAllOutputs(floatReq), .clockSourceSelect(clkSel),
		.crystalInput(xtal), .modePins(2'h2), .sysReset(sysReset), .modReset(modReset),
		.portReset(portReset), .outputsFloat(outputsFloat), .modeCfg(modeCfg), .modeSelExt(modeExt),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr)
	);
	rcs_pin_model u_rcs_pin_model (.clk(clk), .holdReq(hold), .devOe(rstPinOe), .pinLevel(rstPinIn));
	// One APB transfer; a spare edge after release keeps calls back to back safe
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Waits as long as the slave takes; only the watchdog ends a hang
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rd
	// Bounded wait for reset exit
	task automatic waitExit();
		int n;
		n = 0;
		while (sysReset !== 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk({30'h0, portReset, sysReset}, 32'h0);
	endtask : waitExit
	task automatic intRst(input logic [3:0] q, input logic [31:0] x);
		intReq <= q;
		repeat (20) @(posedge clk);
		chk({31'h0, rstPinOe}, 32'h1);
		intReq <= 4'h0;
		waitExit();
		rd(RCS_ADDR_CAUSE, x);
	endtask : intRst
	// One crystal pulse, two clocks high and two low, wide enough to survive sync
	task automatic xtalPulse();
		xtal <= 1'b1;
		repeat (2) @(posedge clk);
		xtal <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : xtalPulse
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict
	// Whole run needs under 1000 cycles; 4000 means a hang
	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		supplyGood <= 1'b1;
		repeat (12) @(posedge clk);
		chk({29'h0, portReset, modReset, sysReset}, 32'h7);
		chk({31'h0, pinData}, 32'h0);
		pllLocked <= 1'b1;
		waitExit();
		rd(RCS_ADDR_CAUSE, 32'h40);
		rd(RCS_ADDR_CTRL, 32'h0);
		rd(RCS_ADDR_STATE, 32'h8);
		apb(1'b1, RCS_ADDR_CAUSE, 32'hFF);
		rd(RCS_ADDR_CAUSE, 32'h40);
		apb(1'b0, 8'h0C, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test power-on done");
		foreach (reqs[i]) intRst(reqs[i], exps[i]);
		intReq <= 4'h2;
		repeat (10) @(posedge clk);
		chk({31'h0, sysReset}, 32'h0);
		intReq <= 4'h0;
		apb(1'b1, RCS_ADDR_CTRL, 32'h3);
		intRst(4'h2, 32'h04);
		$display("test internal done");
		// Bus cycle held open: the pin request must wait for its end
		busEnd <= 1'b0;
		hold <= 1'b1;
		repeat (6) @(posedge clk);
		chk({31'h0, sysReset}, 32'h0);
		hold <= 1'b0;
		busEnd <= 1'b1;
		repeat (2) @(posedge clk);
		chk({31'h0, sysReset}, 32'h1);
		waitExit();
		rd(RCS_ADDR_CAUSE, 32'h80);
		// Pin held low across a release window forces another drive
		intReq <= 4'h8;
		hold <= 1'b1;
		@(posedge clk);
		intReq <= 4'h0;
		repeat (24) @(posedge clk);
		chk({31'h0, sysReset}, 32'h1);
		hold <= 1'b0;
		waitExit();
		rd(RCS_ADDR_CAUSE, 32'h20);
		$display("test pin done");
		floatReq <= 1'b1;
		repeat (6) @(posedge clk);
		floatReq <= 1'b0;
		repeat (4) @(posedge clk);
		chk({31'h0, outputsFloat}, 32'h0);
		floatReq <= 1'b1;
		repeat (16) @(posedge clk);
		floatReq <= 1'b0;
		repeat (8) @(posedge clk);
		chk({30'h0, outputsFloat, sysReset}, 32'h3);
		rd(RCS_ADDR_STATE, 32'hB);
		$display("test float done");
		// Restart clears the float; the external clock now counts crystal pulses
		rst_n <= 1'b0;
		clkSel <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk({30'h0, outputsFloat, sysReset}, 32'h1);
		floatReq <= 1'b1;
		repeat (3) @(posedge clk);
		repeat (9) xtalPulse();
		chk({31'h0, outputsFloat}, 32'h0);
		xtalPulse();
		chk({30'h0, outputsFloat, modeExt}, 32'h3);
		rd(RCS_ADDR_STATE, 32'h1B);
		$display("test external clock done");
		give_verdict();
	end
endmodule : tb
`default_nettype wire
